// *** amlr_core.sv ***
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Mask one bit 0 stops the 2.5 V or timer channel from raising the alert.
// - Mask one bits 1 to 3 stop the core, main and 5.0 V supply channels.
// - Mask one bits 4 to 6 stop the remote one, local and remote two temperatures.
// - With mask two all set, status two events still alert unless bit 7 of mask one is set.
// - Mask two bit 0 stops the 12 V channel, or the voltage id bit five change in code mode.
// - Mask two bit 1 stops overtemperature conditions.
// - Mask two bits 2 to 4 stop faults on fans one to three.
// - Mask two bit 5 stops the shared pin event: fan four, timer limit or gpio.
// - Mask two bits 6 and 7 stop diode faults on remote one and remote two.
// - Both mask registers come out of reset as zero.
// - The low bits register shows the two low bits of the four voltage results.
// - Reading the low bits register freezes it and the high bytes until each is read.
module amlr_core (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic [7:0]           addr_i,
   input  wire logic [7:0]           wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic      [7:0]           rdata_o,
   input  wire amlr_pkg::amlr_cond_s cond_i,
   input  wire logic [1:0]           pin14_func_i,
   input  wire logic                 pin21_vid_i,
   input  wire logic                 conv_valid_i,
   input  wire amlr_pkg::amlr_conv_s conv_i,
   output logic                      alert_pin_o,
   output logic                      alert_pin_oe_o,
   output logic                      irq_o
);
   localparam int unsigned SRC = amlr_pkg::AMLR_SOURCES;
   localparam int unsigned CH  = amlr_pkg::AMLR_CHANNELS;
   localparam int unsigned RW  = amlr_pkg::AMLR_RES_WIDTH;
   localparam int unsigned EV  = amlr_pkg::AMLR_EVENTS;

   logic [7:0]    mask_one_q;
   logic [7:0]    mask_two_q;
   logic [EV-1:0] int_stat_q;
   logic [EV-1:0] int_en_q;
   logic [EV-1:0] events;
   logic [EV-1:0] int_clr;
   logic          alert_q;
   logic          alert_d;
   logic          override_path;
   logic [SRC-1:0] src_vec;
   logic [SRC-1:0] mask_vec;
   logic [SRC-1:0] gated;
   logic          shared_event;
   logic [CH-1:0] pending_q;
   logic [CH-1:0] rd_high;
   logic          rd_low;
   logic          freeze_now;
   logic          release_ev;
   logic          updated;
   logic [7:0]    rdata_d;
   logic [7:0]    low_bits;
   amlr_pkg::amlr_freeze_e freeze_q;
   amlr_pkg::amlr_conv_s   disp;

   ////////////////////////////////////////////////////////////////////
   // register port
   assign rd_low = rd_i && (addr_i == amlr_pkg::AMLR_OFS_LOW_BITS);
   assign int_clr = (wr_i && addr_i == amlr_pkg::AMLR_OFS_INT_CLR) ? wdata_i[EV-1:0] : '0;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mask_one_q <= amlr_pkg::AMLR_MASK_RESET;
         mask_two_q <= amlr_pkg::AMLR_MASK_RESET;
      end
      else if (wr_i && addr_i == amlr_pkg::AMLR_OFS_MASK_ONE)
         mask_one_q <= wdata_i;
      else if (wr_i && addr_i == amlr_pkg::AMLR_OFS_MASK_TWO)
         mask_two_q <= wdata_i;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         int_en_q <= amlr_pkg::AMLR_INT_RESET;
      else if (wr_i && addr_i == amlr_pkg::AMLR_OFS_INT_EN)
         int_en_q <= wdata_i[EV-1:0];
   end

   // low bits in channel order, two per channel
   always_comb
   begin
      low_bits = '0;
      for (int k = 0; k < CH; k++)
         low_bits[2*k +: 2] = disp.result[k][1:0];
   end

   always_comb
   begin
      rdata_d = 8'h00;
      case (addr_i)
         amlr_pkg::AMLR_OFS_MASK_ONE: rdata_d = mask_one_q;
         amlr_pkg::AMLR_OFS_MASK_TWO: rdata_d = mask_two_q;
         amlr_pkg::AMLR_OFS_LOW_BITS: rdata_d = low_bits;
         amlr_pkg::AMLR_OFS_INT_STAT: rdata_d = {5'h00, int_stat_q};
         amlr_pkg::AMLR_OFS_INT_EN:   rdata_d = {5'h00, int_en_q};
         default:
            for (int k = 0; k < CH; k++)
               if (addr_i == amlr_pkg::AMLR_OFS_HIGH_0 + 8'(k))
                  rdata_d = disp.result[k][RW-1:2];
      endcase
   end

   // read data stands for one cycle only, zero otherwise
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_o <= 8'h00;
      else
         rdata_o <= rd_i ? rdata_d : 8'h00;
   end

   ////////////////////////////////////////////////////////////////////
   // alert masking
   always_comb
   begin
      case (amlr_pkg::amlr_pin14_e'(pin14_func_i))
         amlr_pkg::AMLR_PIN14_FAN:   shared_event = cond_i.fan_four_fault;
         amlr_pkg::AMLR_PIN14_TIMER: shared_event = cond_i.timer_limit;
         amlr_pkg::AMLR_PIN14_GPIO:  shared_event = cond_i.gpio_asserted;
         default:                    shared_event = 1'b0;
      endcase
   end

   assign src_vec = {cond_i.diode_fault, shared_event, cond_i.fan_fault, cond_i.overtemp,
                     pin21_vid_i ? cond_i.voltage_id_bit_five : cond_i.high_rail_limit,
                     cond_i.out_of_limit};
   assign mask_vec = {mask_two_q, mask_one_q[6:0]};

   // one gate per source; mask bit set blocks the source
   for (genvar g = 0; g < SRC; g++)
   begin : g_gate
      assign gated[g] = src_vec[g] && !mask_vec[g];
   end

   // with mask two all set, status two sources bypass their masks unless the override is set
   assign override_path = (mask_two_q == amlr_pkg::AMLR_ALL_MASKED)
                          && !mask_one_q[amlr_pkg::AMLR_OVERRIDE_BIT]
                          && (|src_vec[SRC-1:7]);
   assign alert_d = (|gated) || override_path;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         alert_q <= 1'b0;
      else
         alert_q <= alert_d;
   end

   // open drain, active low: only ever pulls the line down
   assign alert_pin_o    = 1'b0;
   assign alert_pin_oe_o = alert_q;

   ////////////////////////////////////////////////////////////////////
   // read freeze
   for (genvar g = 0; g < CH; g++)
   begin : g_high
      assign rd_high[g] = rd_i && (addr_i == amlr_pkg::AMLR_OFS_HIGH_0 + 8'(g));
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         pending_q <= '0;
      else if (rd_low)
         pending_q <= '1;
      else
         pending_q <= pending_q & ~rd_high;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         freeze_q <= amlr_pkg::AMLR_LIVE;
      else
         case (freeze_q)
            amlr_pkg::AMLR_LIVE:
               if (rd_low)
                  freeze_q <= amlr_pkg::AMLR_FROZEN;
            amlr_pkg::AMLR_FROZEN:
               if (!rd_low && (pending_q & ~rd_high) == '0)
                  freeze_q <= amlr_pkg::AMLR_LIVE;
            default:
               freeze_q <= amlr_pkg::AMLR_LIVE;
         endcase
   end

   // the read cycle itself already blocks updates, so the pair read stays coherent
   assign freeze_now = (freeze_q == amlr_pkg::AMLR_FROZEN) || rd_low;
   assign release_ev = (freeze_q == amlr_pkg::AMLR_FROZEN) && !rd_low
                       && (pending_q & ~rd_high) == '0;

   amlr_hold #(
      .WIDTH (CH*RW)
   ) u_hold (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .load_i    (conv_valid_i),
      .data_i    (conv_i),
      .freeze_i  (freeze_now),
      .data_o    (disp),
      .updated_o (updated)
   );

   ////////////////////////////////////////////////////////////////////
   // interrupt status; a new event wins over a clear in the same cycle
   assign events[amlr_pkg::AMLR_EV_ALERT]   = alert_d && !alert_q;
   assign events[amlr_pkg::AMLR_EV_UPDATE]  = updated;
   assign events[amlr_pkg::AMLR_EV_RELEASE] = release_ev;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         int_stat_q <= amlr_pkg::AMLR_INT_RESET;
      else
         int_stat_q <= (int_stat_q & ~int_clr) | events;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |((int_stat_q & ~int_clr | events) & int_en_q);
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_low_read;
      rd_low;
   endsequence

   sequence s_all_high_read;
      freeze_q == amlr_pkg::AMLR_FROZEN && (pending_q & ~rd_high) == '0 && !rd_low;
   endsequence

   mask_reset_a: assert property ($past(rst_i) |->
      mask_one_q == 8'h00 && mask_two_q == 8'h00)
      else $error("mask registers not zero after reset");

   aux_mask_a: assert property (src_vec == 15'h0001 |=> alert_q == !$past(mask_one_q[0]))
      else $error("aux channel mask wrong");

   supply_mask_a: assert property (
      src_vec[SRC-1:4] == '0 && src_vec[0] == 1'b0 && $onehot(src_vec[3:1])
      |=> alert_q == |($past(src_vec[3:1]) & ~$past(mask_one_q[3:1])))
      else $error("supply channel mask wrong");

   temp_mask_a: assert property (
      src_vec[3:0] == '0 && src_vec[SRC-1:7] == '0 && $onehot(src_vec[6:4])
      |=> alert_q == |($past(src_vec[6:4]) & ~$past(mask_one_q[6:4])))
      else $error("temperature mask wrong");

   override_a: assert property (
      mask_two_q == 8'hff && (src_vec[6:0] & ~mask_one_q[6:0]) == '0 && |src_vec[SRC-1:7]
      |=> alert_q == !$past(mask_one_q[7]))
      else $error("status two override wrong");

   rail_code_a: assert property (
      (pin21_vid_i ? cond_i.voltage_id_bit_five : cond_i.high_rail_limit) && !mask_two_q[0]
      |=> alert_q)
      else $error("rail or code source lost");

   overtemp_a: assert property (
      src_vec == 15'h0100 && mask_two_q != 8'hff |=> alert_q == !$past(mask_two_q[1]))
      else $error("overtemperature mask wrong");

   fan_mask_a: assert property (
      src_vec[8:0] == '0 && src_vec[SRC-1:12] == '0 && mask_two_q != 8'hff
      && |src_vec[11:9]
      |=> alert_q == |($past(src_vec[11:9]) & ~$past(mask_two_q[4:2])))
      else $error("fan fault mask wrong");

   shared_pin_a: assert property (
      pin14_func_i == 2'h1 && cond_i.timer_limit && !mask_two_q[5] |=> alert_q)
      else $error("shared pin event lost");

   diode_mask_a: assert property (
      src_vec[12:0] == '0 && $onehot(src_vec[14:13]) && mask_two_q != 8'hff
      |=> alert_q == |($past(src_vec[14:13]) & ~$past(mask_two_q[7:6])))
      else $error("diode fault mask wrong");

   low_bits_a: assert property (s_low_read |=>
      rdata_o == {$past(disp.result[3][1:0]), $past(disp.result[2][1:0]),
                  $past(disp.result[1][1:0]), $past(disp.result[0][1:0])})
      else $error("low bits read wrong");

   freeze_set_a: assert property (s_low_read |=>
      freeze_q == amlr_pkg::AMLR_FROZEN && pending_q == 4'hf)
      else $error("freeze not taken");

   freeze_hold_a: assert property (freeze_now |=> $stable(disp))
      else $error("results moved while frozen");

   freeze_end_a: assert property (s_all_high_read |=>
      freeze_q == amlr_pkg::AMLR_LIVE)
      else $error("freeze not released");

   alert_clear_a: assert property (src_vec == '0 |=> !alert_pin_oe_o)
      else $error("alert stuck without cause");
endmodule // amlr_core
`default_nettype wire

// *** amlr_hold.sv ***
`timescale 1ns/1ps
`default_nettype none
// keeps the newest sample aside while frozen so the latest conversion is not lost
module amlr_hold #(
   parameter int unsigned WIDTH = 40
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] data_i,
   input  wire logic             freeze_i,
   output logic      [WIDTH-1:0] data_o,
   output logic                  updated_o
);
   logic [WIDTH-1:0] shadow_q;
   logic             fresh_q;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         shadow_q <= '0;
      else if (load_i)
         shadow_q <= data_i;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         fresh_q <= 1'b0;
      else if (freeze_i)
         fresh_q <= fresh_q | load_i;
      else
         fresh_q <= 1'b0;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         data_o    <= '0;
         updated_o <= 1'b0;
      end
      else
      begin
         updated_o <= !freeze_i && (load_i || fresh_q);
         if (!freeze_i && load_i)
            data_o <= data_i;
         else if (!freeze_i && fresh_q)
            data_o <= shadow_q;
      end
   end
endmodule // amlr_hold
`default_nettype wire

// *** amlr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// host side of the register port: one-cycle strobes, never both at once
module amlr_host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o
);
   initial
   begin
      addr_o  = 8'h00;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   // released address and data are scrambled so nothing leans on stale values
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask
endmodule // amlr_host_model
`default_nettype wire

// *** amlr_pkg.sv ***
`default_nettype none
package amlr_pkg;
   localparam int unsigned AMLR_RES_WIDTH = 10;
   localparam int unsigned AMLR_CHANNELS  = 4;
   localparam int unsigned AMLR_SOURCES   = 15;
   localparam int unsigned AMLR_EVENTS    = 3;
   ////////////////////////////////////////////////////////////////////
   localparam logic [7:0] AMLR_OFS_MASK_ONE = 8'h74;
   localparam logic [7:0] AMLR_OFS_MASK_TWO = 8'h75;
   localparam logic [7:0] AMLR_OFS_LOW_BITS = 8'h76;
   localparam logic [7:0] AMLR_OFS_HIGH_0   = 8'h20;
   localparam logic [7:0] AMLR_OFS_INT_STAT = 8'h60;
   localparam logic [7:0] AMLR_OFS_INT_CLR  = 8'h61;
   localparam logic [7:0] AMLR_OFS_INT_EN   = 8'h62;
   localparam logic [7:0] AMLR_MASK_RESET   = 8'h00;
   localparam logic [7:0] AMLR_ALL_MASKED   = 8'hff;
   localparam logic [2:0] AMLR_INT_RESET    = 3'h0;
   localparam int unsigned AMLR_OVERRIDE_BIT = 7;
   localparam int unsigned AMLR_EV_ALERT    = 0;
   localparam int unsigned AMLR_EV_UPDATE   = 1;
   localparam int unsigned AMLR_EV_RELEASE  = 2;
   ////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      AMLR_PIN14_FAN   = 2'h0,
      AMLR_PIN14_TIMER = 2'h1,
      AMLR_PIN14_ALERT = 2'h2,
      AMLR_PIN14_GPIO  = 2'h3
   } amlr_pin14_e;
   typedef enum logic {
      AMLR_LIVE   = 1'b0,
      AMLR_FROZEN = 1'b1
   } amlr_freeze_e;
   typedef struct packed {
      logic [1:0] diode_fault;
      logic       gpio_asserted;
      logic       timer_limit;
      logic       fan_four_fault;
      logic [2:0] fan_fault;
      logic       overtemp;
      logic       voltage_id_bit_five;
      logic       high_rail_limit;
      logic [6:0] out_of_limit;
   } amlr_cond_s;
   typedef struct packed {
      logic [AMLR_CHANNELS-1:0][AMLR_RES_WIDTH-1:0] result;
   } amlr_conv_s;
endpackage
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                 clk_i;
   logic                 rst_i;
   logic [7:0]           addr_i;
   logic [7:0]           wdata_i;
   logic                 wr_i;
   logic                 rd_i;
   logic [7:0]           rdata_o;
   amlr_pkg::amlr_cond_s cond_i;
   logic [1:0]           pin14_func_i;
   logic                 pin21_vid_i;
   logic                 conv_valid_i;
   amlr_pkg::amlr_conv_s conv_i;
   logic                 alert_pin_o;
   logic                 alert_pin_oe_o;
   logic                 irq_o;
   int                   num_errors;
   int                   compares;
   int                   seed;
   logic [7:0]           m1;
   logic [7:0]           m2;
   logic [7:0]           d;
   logic [1:0]           f;
   logic                 v;
   amlr_pkg::amlr_cond_s c;
   amlr_pkg::amlr_conv_s ca;
   amlr_pkg::amlr_conv_s cb;
   ////////////////////////////////////////////////////////////////////
   amlr_core uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cond_i(cond_i),
      .pin14_func_i(pin14_func_i), .pin21_vid_i(pin21_vid_i), .conv_valid_i(conv_valid_i),
      .conv_i(conv_i), .alert_pin_o(alert_pin_o), .alert_pin_oe_o(alert_pin_oe_o),
      .irq_o(irq_o));
   amlr_host_model host (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i),
      .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
   always #12.5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] r;
      host.rd_reg(a, r);
      chk_byte(r, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic send_conv(input amlr_pkg::amlr_conv_s x);
      @(posedge clk_i);
      conv_i       <= x;
      conv_valid_i <= 1'b1;
      @(posedge clk_i);
      conv_valid_i <= 1'b0;
   endtask
   // high bytes are read in full after the low bits, which also ends the freeze
   task automatic chk_high(input amlr_pkg::amlr_conv_s x);
      for (int k = 0; k < 4; k++)
         rd_chk(amlr_pkg::AMLR_OFS_HIGH_0 + 8'(k), x.result[k][9:2]);
   endtask
   function automatic logic [7:0] low_bits(input amlr_pkg::amlr_conv_s x);
      return {x.result[3][1:0], x.result[2][1:0], x.result[1][1:0], x.result[0][1:0]};
   endfunction
   function automatic logic exp_alert(input amlr_pkg::amlr_cond_s k, input logic [7:0] a,
                                      input logic [7:0] b, input logic [1:0] p, input logic q);
      logic [7:0] s;
      s = {k.diode_fault, (p == 2'h0 & k.fan_four_fault) | (p == 2'h1 & k.timer_limit) |
           (p == 2'h3 & k.gpio_asserted), k.fan_fault, k.overtemp,
           q ? k.voltage_id_bit_five : k.high_rail_limit};
      return (|(k.out_of_limit & ~a[6:0])) | (|(s & ~b)) | (b == 8'hff & !a[7] & (|s));
   endfunction
   task automatic give_verdict;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (60000) @(posedge clk_i);
      num_errors++;
      give_verdict;
   end
   initial
   begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      cond_i = '0;
      pin14_func_i = 2'h0;
      pin21_vid_i = 1'b0;
      conv_valid_i = 1'b0;
      conv_i = '0;
      num_errors = 0;
      compares = 0;
      seed = 96;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(amlr_pkg::AMLR_OFS_MASK_ONE, amlr_pkg::AMLR_MASK_RESET);
      rd_chk(amlr_pkg::AMLR_OFS_MASK_TWO, amlr_pkg::AMLR_MASK_RESET);
      rd_chk(amlr_pkg::AMLR_OFS_LOW_BITS, 8'h00);
      chk_high('0);
      rd_chk(8'h7f, 8'h00);
      // freeze: a conversion arriving mid-read must stay hidden until all reads end
      ca = amlr_pkg::amlr_conv_s'(40'({$random(seed), $random(seed)}));
      cb = amlr_pkg::amlr_conv_s'(40'({$random(seed), $random(seed)}));
      send_conv(ca);
      cyc(2);
      host.wr_reg(amlr_pkg::AMLR_OFS_LOW_BITS, ~low_bits(ca));
      rd_chk(amlr_pkg::AMLR_OFS_LOW_BITS, low_bits(ca));
      send_conv(cb);
      cyc(2);
      chk_high(ca);
      cyc(3);
      rd_chk(amlr_pkg::AMLR_OFS_LOW_BITS, low_bits(cb));
      chk_high(cb);
      // interrupt: raise, clear, mask through enable
      host.wr_reg(amlr_pkg::AMLR_OFS_INT_EN, 8'h01);
      host.wr_reg(amlr_pkg::AMLR_OFS_INT_CLR, 8'h07);
      cyc(2);
      chk_bit(irq_o, 1'b0);
      rd_chk(amlr_pkg::AMLR_OFS_INT_EN, 8'h01);
      @(posedge clk_i);
      cond_i <= amlr_pkg::amlr_cond_s'(15'h0001);
      cyc(3);
      chk_bit(irq_o, 1'b1);
      host.rd_reg(amlr_pkg::AMLR_OFS_INT_STAT, d);
      chk_bit(d[0], 1'b1);
      @(posedge clk_i);
      cond_i <= '0;
      host.wr_reg(amlr_pkg::AMLR_OFS_INT_CLR, 8'h01);
      cyc(2);
      chk_bit(irq_o, 1'b0);
      chk_bit(alert_pin_oe_o, 1'b0);
      host.wr_reg(amlr_pkg::AMLR_OFS_INT_EN, 8'h00);
      @(posedge clk_i);
      cond_i <= amlr_pkg::amlr_cond_s'(15'h0001);
      cyc(3);
      chk_bit(irq_o, 1'b0);
      // masks: each source alone unmasked then fully masked, then random mixes
      for (int i = 0; i < 160; i++)
      begin
         f = 2'($random(seed));
         v = 1'($random(seed));
         // walk all 18 condition bits; diode sources are always reached, gpio only when f picks the gpio function (2'h3)
         if (i < 36)
         begin
            c = amlr_pkg::amlr_cond_s'(18'h00001 << (i % 18));
            m1 = (i < 18) ? 8'h00 : 8'hff;
            m2 = m1;
         end
         else
         begin
            c = amlr_pkg::amlr_cond_s'(18'($random(seed) & $random(seed)));
            m1 = 8'($random(seed));
            m2 = (($random(seed) & 3) == 0) ? amlr_pkg::AMLR_ALL_MASKED : 8'($random(seed));
         end
         // the far side only reports events that its pin functions allow
         if (f != 2'h0)
            c.fan_four_fault = 1'b0;
         if (f != 2'h1)
            c.timer_limit = 1'b0;
         if (f != 2'h3)
            c.gpio_asserted = 1'b0;
         if (v)
            c.high_rail_limit = 1'b0;
         else
            c.voltage_id_bit_five = 1'b0;
         host.wr_reg(amlr_pkg::AMLR_OFS_MASK_ONE, m1);
         host.wr_reg(amlr_pkg::AMLR_OFS_MASK_TWO, m2);
         @(posedge clk_i);
         cond_i <= c;
         pin14_func_i <= f;
         pin21_vid_i <= v;
         cyc(2);
         chk_bit(alert_pin_oe_o, exp_alert(c, m1, m2, f, v));
         chk_bit(alert_pin_o, 1'b0);
         if (i % 8 == 0)
            rd_chk(amlr_pkg::AMLR_OFS_MASK_TWO, m2);
      end
      give_verdict;
   end
endmodule // testbench
`default_nettype wire
